// ### hdl/nvm_defs.svh
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

// register addresses
`define ADDR_IRQ_ENABLE_TWO   12'hfa0
`define ADDR_IRQ_FLAGS_TWO    12'hfa1
`define ADDR_IRQ_PRIORITY_TWO 12'hfa2
`define ADDR_NVM_CONTROL      12'hfa6
`define ADDR_NVM_UNLOCK_KEY   12'hfa7
`define ADDR_NVM_DATA         12'hfa8
`define ADDR_NVM_ADDRESS      12'hfa9
`define ADDR_CORE_IRQ_CONTROL 12'hff2

// control and interrupt register fields
`define CTL_PROG_SEL 7
`define CTL_CFG_SEL  6
`define CTL_WR_GATE  2
`define CTL_WR       1
`define CTL_RD       0
`define CTL_SW_MASK  8'hdc
`define FLAG_WRITE_DONE 4
`define IRQ_FIELD_MASK  8'h1f

// reset values
`define RST_IRQ_ENABLE 8'h00
`define RST_IRQ_FLAGS  8'h00
`define RST_IRQ_PRIO   8'h1f
`define RST_CONTROL    8'h00
`define RST_DATA       8'h00
`define RST_ADDR       8'h00
`define RST_CORE_IRQ   8'h00
`define ZERO_BYTE      8'h00

// unlock keys
`define KEY_FIRST  8'h55
`define KEY_SECOND 8'haa

// timing
`define CLK_FREQ_KHZ 100000
`define CLK_FREQ_MHZ 100
`define PWRT_TIME_MS 72
`define PROG_TIME_US 4000
`define TIMER_W      23
`define TIMER_ZERO   23'h000000
`endif

// ### hdl/nvm_pkg.sv
`include "nvm_defs.svh"
package nvm_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } sfr_req_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ext_req_t;

   typedef struct packed {
      logic       valid;
      logic       denied;
      logic [7:0] rdata;
   } ext_resp_t;

   typedef enum logic [2:0] {
      KEY_IDLE        = 3'b001,
      KEY_GOT_FIRST   = 3'b010,
      KEY_ARMED       = 3'b100
   } key_state_t;

   typedef struct packed {
      key_state_t            key;
      logic [7:0]            control;
      logic [7:0]            data;
      logic [7:0]            addr;
      logic [7:0]            irq_enable;
      logic [7:0]            irq_flags;
      logic [7:0]            irq_prio;
      logic [7:0]            core_irq;
      logic [`TIMER_W-1:0]   pwrt_cnt;
      logic [`TIMER_W-1:0]   prog_cnt;
      logic [7:0]            sfr_rdata;
      ext_resp_t             ext_resp;
      logic                  irq_high;
      logic                  irq_low;
   } ctrl_state_t;

   typedef struct packed {
      logic [255:0][7:0] cells;
   } mem_state_t;
endpackage : nvm_pkg

// ### hdl/nvm_cell_array.sv
`timescale 1ns/1ns
module nvm_cell_array
   import nvm_pkg::*;
(
   // clock
   input  wire logic       clk_in,
   // write port
   input  wire logic       we_in,
   input  wire logic [7:0] waddr_in,
   input  wire logic [7:0] wdata_in,
   // read ports
   input  wire logic [7:0] raddr_a_in,
   output      logic [7:0] rdata_a_out,
   input  wire logic [7:0] raddr_b_in,
   output      logic [7:0] rdata_b_out
);
   mem_state_t st;
   mem_state_t next_st;

   // cells are nonvolatile, so no reset
   always_comb begin
      next_st = st;
      if (we_in) begin
         next_st.cells[waddr_in] = wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      st <= next_st;
   end

   assign rdata_a_out = st.cells[raddr_a_in];
   assign rdata_b_out = st.cells[raddr_b_in];
endmodule : nvm_cell_array

// ### hdl/data_eeprom_access_ctrl.sv
`timescale 1ns/1ns
`include "nvm_defs.svh"
module data_eeprom_access_ctrl
   import nvm_pkg::*;
#(
   parameter int unsigned PWRT_CYCLES = `PWRT_TIME_MS * `CLK_FREQ_KHZ,
   parameter int unsigned PROG_CYCLES = `PROG_TIME_US * `CLK_FREQ_MHZ
)
(
   // clock and reset
   input  wire logic       SYS_CLK_IN,
   input  wire logic       RST_N_IN,
   // cpu register port
   input  wire sfr_req_t   SFR_REQ_IN,
   output      logic [7:0] SFR_RDATA_OUT,
   // external programming port
   input  wire ext_req_t   EXT_REQ_IN,
   input  wire logic       CODE_PROTECT_IN,
   output      ext_resp_t  EXT_RESP_OUT,
   // status and interrupt requests
   output      logic       WRITE_BUSY_OUT,
   output      logic       IRQ_HIGH_OUT,
   output      logic       IRQ_LOW_OUT
);
   ctrl_state_t st;
   ctrl_state_t next_st;

   logic       busy;
   logic       rd_fire;
   logic       start;
   logic       finish;
   logic       data_wr_ok;
   logic       ctl_wr_ok;
   logic       ext_mem_wr;
   logic       mem_we;
   logic [7:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic [7:0] cpu_rdata;
   logic [7:0] ext_rdata;

   function automatic logic [`TIMER_W-1:0] count_down(input logic [`TIMER_W-1:0] cnt);
      count_down = (cnt == `TIMER_ZERO) ? `TIMER_ZERO : cnt - 1'b1;
   endfunction : count_down

   function automatic logic is_write(input sfr_req_t req, input logic [11:0] where);
      is_write = req.wr && (req.addr == where);
   endfunction : is_write

   always_comb begin
      next_st    = st;
      busy       = st.control[`CTL_WR];
      rd_fire    = 1'b0;
      start      = 1'b0;
      finish     = 1'b0;
      data_wr_ok = 1'b0;
      ctl_wr_ok  = 1'b0;
      ext_mem_wr = 1'b0;

      // cpu programming writes are refused until this reaches zero
      next_st.pwrt_cnt = count_down(st.pwrt_cnt);

      if (busy) begin
         if (st.prog_cnt == `TIMER_ZERO) begin
            finish                   = 1'b1;
            next_st.control[`CTL_WR] = 1'b0;
         end else begin
            next_st.prog_cnt = count_down(st.prog_cnt);
         end
      end

      if (SFR_REQ_IN.wr) begin
         if (SFR_REQ_IN.addr != `ADDR_NVM_UNLOCK_KEY) begin
            next_st.key = KEY_IDLE;
         end
         case (SFR_REQ_IN.addr)
            `ADDR_IRQ_ENABLE_TWO: begin
               next_st.irq_enable = SFR_REQ_IN.wdata & `IRQ_FIELD_MASK;
            end
            `ADDR_IRQ_FLAGS_TWO: begin
               next_st.irq_flags = SFR_REQ_IN.wdata & `IRQ_FIELD_MASK;
            end
            `ADDR_IRQ_PRIORITY_TWO: begin
               next_st.irq_prio = SFR_REQ_IN.wdata & `IRQ_FIELD_MASK;
            end
            `ADDR_CORE_IRQ_CONTROL: begin
               next_st.core_irq = SFR_REQ_IN.wdata;
            end
            // observed only, nothing stored
            `ADDR_NVM_UNLOCK_KEY: begin
               if (SFR_REQ_IN.wdata == `KEY_FIRST) begin
                  next_st.key = KEY_GOT_FIRST;
               end else if (SFR_REQ_IN.wdata == `KEY_SECOND && st.key == KEY_GOT_FIRST) begin
                  next_st.key = KEY_ARMED;
               end else begin
                  next_st.key = KEY_IDLE;
               end
            end
            `ADDR_NVM_CONTROL: begin
               if (!busy) begin
                  ctl_wr_ok = 1'b1;
                  // strobes are never stored from the bus, only set below
                  next_st.control = SFR_REQ_IN.wdata & `CTL_SW_MASK;
                  // selects must point at the data array
                  if (SFR_REQ_IN.wdata[`CTL_RD] && !SFR_REQ_IN.wdata[`CTL_PROG_SEL]
                      && !SFR_REQ_IN.wdata[`CTL_CFG_SEL]) begin
                     rd_fire = 1'b1;
                  end
                  // enable is the stored bit, so one write cannot set both
                  if (SFR_REQ_IN.wdata[`CTL_WR] && st.control[`CTL_WR_GATE]
                      && st.key == KEY_ARMED
                      && st.pwrt_cnt == `TIMER_ZERO
                      && !SFR_REQ_IN.wdata[`CTL_PROG_SEL]
                      && !SFR_REQ_IN.wdata[`CTL_CFG_SEL]) begin
                     start = 1'b1;
                  end
               end
            end
            `ADDR_NVM_DATA: begin
               if (!busy) begin
                  data_wr_ok   = 1'b1;
                  next_st.data = SFR_REQ_IN.wdata;
               end
            end
            `ADDR_NVM_ADDRESS: begin
               if (!busy) begin
                  next_st.addr = SFR_REQ_IN.wdata;
               end
            end
            default: begin
            end
         endcase
      end

      // read lands in the same edge so the next instruction sees it
      next_st.control[`CTL_RD] = rd_fire;
      if (rd_fire) begin
         next_st.data = cpu_rdata;
      end
      if (start) begin
         next_st.control[`CTL_WR] = 1'b1;
         next_st.prog_cnt         = `TIMER_W'(PROG_CYCLES - 1);
      end
      // hardware set after the software write: the set wins
      if (finish) begin
         next_st.irq_flags[`FLAG_WRITE_DONE] = 1'b1;
      end

      next_st.sfr_rdata = `ZERO_BYTE;
      if (SFR_REQ_IN.rd) begin
         case (SFR_REQ_IN.addr)
            `ADDR_IRQ_ENABLE_TWO:   next_st.sfr_rdata = st.irq_enable;
            `ADDR_IRQ_FLAGS_TWO:    next_st.sfr_rdata = st.irq_flags;
            `ADDR_IRQ_PRIORITY_TWO: next_st.sfr_rdata = st.irq_prio;
            `ADDR_CORE_IRQ_CONTROL: next_st.sfr_rdata = st.core_irq;
            `ADDR_NVM_CONTROL:      next_st.sfr_rdata = st.control;
            `ADDR_NVM_DATA:         next_st.sfr_rdata = st.data;
            `ADDR_NVM_ADDRESS:      next_st.sfr_rdata = st.addr;
            default:                next_st.sfr_rdata = `ZERO_BYTE;
         endcase
      end

      // programmer is refused while protected or while the cpu is writing
      next_st.ext_resp = '0;
      if (EXT_REQ_IN.rd || EXT_REQ_IN.wr) begin
         next_st.ext_resp.valid = 1'b1;
         if (CODE_PROTECT_IN || busy) begin
            next_st.ext_resp.denied = 1'b1;
         end else begin
            if (EXT_REQ_IN.rd) begin
               next_st.ext_resp.rdata = ext_rdata;
            end
            ext_mem_wr = EXT_REQ_IN.wr;
         end
      end

      next_st.irq_high = |(st.irq_flags & st.irq_enable & st.irq_prio);
      next_st.irq_low  = |(st.irq_flags & st.irq_enable & ~st.irq_prio);
   end

   // ext write only happens when idle, so it never meets a completion
   assign mem_we    = finish || ext_mem_wr;
   assign mem_waddr = finish ? st.addr : EXT_REQ_IN.addr;
   assign mem_wdata = finish ? st.data : EXT_REQ_IN.wdata;

   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         st            <= '0;
         st.key        <= KEY_IDLE;
         st.control    <= `RST_CONTROL;
         st.data       <= `RST_DATA;
         st.addr       <= `RST_ADDR;
         st.irq_enable <= `RST_IRQ_ENABLE;
         st.irq_flags  <= `RST_IRQ_FLAGS;
         st.irq_prio   <= `RST_IRQ_PRIO;
         st.core_irq   <= `RST_CORE_IRQ;
         st.pwrt_cnt   <= `TIMER_W'(PWRT_CYCLES);
      end else begin
         st <= next_st;
      end
   end

   nvm_cell_array u_cells (
      .clk_in      (SYS_CLK_IN),
      .we_in       (mem_we),
      .waddr_in    (mem_waddr),
      .wdata_in    (mem_wdata),
      .raddr_a_in  (st.addr),
      .rdata_a_out (cpu_rdata),
      .raddr_b_in  (EXT_REQ_IN.addr),
      .rdata_b_out (ext_rdata)
   );

   assign SFR_RDATA_OUT  = st.sfr_rdata;
   assign EXT_RESP_OUT   = st.ext_resp;
   assign WRITE_BUSY_OUT = st.control[`CTL_WR];
   assign IRQ_HIGH_OUT   = st.irq_high;
   assign IRQ_LOW_OUT    = st.irq_low;

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   read_data_next_a: assert property (
      rd_fire |=> (st.data == $past(cpu_rdata)) && st.control[`CTL_RD])
      else $error("read byte not in data register next cycle");

   data_hold_a: assert property (
      !(rd_fire || data_wr_ok) |=> $stable(st.data))
      else $error("data register changed without read or write");

   start_needs_key_a: assert property (
      $rose(st.control[`CTL_WR]) |-> $past(st.key) == KEY_ARMED)
      else $error("write started without unlock sequence");

   start_needs_gate_a: assert property (
      $rose(st.control[`CTL_WR]) |-> $past(st.control[`CTL_WR_GATE]))
      else $error("write started without prior write enable");

   gate_kept_a: assert property (
      st.control[`CTL_WR_GATE] && !ctl_wr_ok |=> st.control[`CTL_WR_GATE])
      else $error("write enable cleared by hardware");

   write_lock_a: assert property (
      busy && !finish |=> $stable(st.addr) && $stable(st.data)
         && $stable(st.control[`CTL_WR_GATE]))
      else $error("registers changed during write");

   done_sets_flag_a: assert property (
      finish |=> !st.control[`CTL_WR] && st.irq_flags[`FLAG_WRITE_DONE])
      else $error("completion did not clear strobe and set flag");

   flag_sticky_a: assert property (
      st.irq_flags[`FLAG_WRITE_DONE] && !is_write(SFR_REQ_IN, `ADDR_IRQ_FLAGS_TWO)
      |=> st.irq_flags[`FLAG_WRITE_DONE])
      else $error("done flag cleared without software");

   pwrt_block_a: assert property (
      st.pwrt_cnt != `TIMER_ZERO |-> !start)
      else $error("write started while power-up timer runs");

   ext_protect_a: assert property (
      CODE_PROTECT_IN && (EXT_REQ_IN.rd || EXT_REQ_IN.wr)
      |-> !ext_mem_wr ##1 EXT_RESP_OUT.denied && EXT_RESP_OUT.rdata == `ZERO_BYTE)
      else $error("external access under code protect");

   rd_one_cycle_a: assert property (
      st.control[`CTL_RD] |=> !st.control[`CTL_RD] || $past(rd_fire))
      else $error("read strobe not self clearing");

   key_reset_a: assert property (
      SFR_REQ_IN.wr && SFR_REQ_IN.addr != `ADDR_NVM_UNLOCK_KEY |=> st.key == KEY_IDLE)
      else $error("unlock tracker survived another write");

   busy_span_a: assert property (
      start |=> st.control[`CTL_WR] [*8])
      else $error("write strobe dropped early");

   irq_gate_a: assert property (
      IRQ_HIGH_OUT || IRQ_LOW_OUT
      |-> $past(|(st.irq_flags & st.irq_enable)))
      else $error("interrupt request without enabled flag");

   key_advance_a: assert property (
      is_write(SFR_REQ_IN, `ADDR_NVM_UNLOCK_KEY) && SFR_REQ_IN.wdata == `KEY_FIRST
      |=> st.key == KEY_GOT_FIRST)
      else $error("unlock tracker missed first key");

   key_reads_zero_a: assert property (
      SFR_REQ_IN.rd && SFR_REQ_IN.addr == `ADDR_NVM_UNLOCK_KEY
      |=> SFR_RDATA_OUT == `ZERO_BYTE)
      else $error("unlock register returned stored data");

   rd_zero_noop_a: assert property (
      is_write(SFR_REQ_IN, `ADDR_NVM_CONTROL) && !SFR_REQ_IN.wdata[`CTL_RD]
      |=> !st.control[`CTL_RD] && $stable(st.data))
      else $error("zero read strobe caused a read");

   irq_high_level_a: assert property (
      |(st.irq_flags & st.irq_enable & st.irq_prio) |=> IRQ_HIGH_OUT)
      else $error("enabled high priority flag gave no request");

   ext_busy_deny_a: assert property (
      busy && (EXT_REQ_IN.rd || EXT_REQ_IN.wr) |-> !ext_mem_wr ##1 EXT_RESP_OUT.denied)
      else $error("external access taken during cpu write");

   rdata_idle_a: assert property (
      !SFR_REQ_IN.rd |=> SFR_RDATA_OUT == `ZERO_BYTE)
      else $error("read data shown without a read");
endmodule : data_eeprom_access_ctrl

// ### verification/ext_prog_model.sv
`timescale 1ns/1ns
module ext_prog_model
   import nvm_pkg::*;
(
   // clock
   input  wire logic      clk_in,
   // programming port
   output      ext_req_t  req_out,
   input  wire ext_resp_t resp_in
);
   initial req_out = '0;

   task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [7:0] d,
                       output ext_resp_t r);
      @(negedge clk_in);
      req_out = '{wr: is_wr, rd: !is_wr, addr: a, wdata: d};
      @(negedge clk_in);
      r = resp_in;
      // released lines invert so a stale value never passes for a driven one
      req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : xfer
endmodule : ext_prog_model

// ### verification/tb_data_eeprom_access_ctrl.sv
`timescale 1ns/1ns
module tb_data_eeprom_access_ctrl
   import nvm_pkg::*;
;
   localparam int unsigned PWRT = 40;
   localparam int unsigned PROG = 16;
   logic       sys_clk      = 1'b0;
   logic       rst_n        = 1'b0;
   sfr_req_t   sfr_req      = '0;
   logic       code_protect = 1'b0;
   logic [7:0] sfr_rdata;
   ext_req_t   ext_req;
   ext_resp_t  ext_resp;
   ext_resp_t  r;
   logic       busy;
   logic       irq_high;
   logic       irq_low;
   int         n_errors     = 0;
   int         n_compared   = 0;
   int         cycles       = 0;
   int         n;

   always #5 sys_clk = ~sys_clk;

   data_eeprom_access_ctrl #(.PWRT_CYCLES(PWRT), .PROG_CYCLES(PROG)) data_eeprom_access_ctrl_inst (
      .SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .SFR_REQ_IN(sfr_req), .SFR_RDATA_OUT(sfr_rdata),
      .EXT_REQ_IN(ext_req), .CODE_PROTECT_IN(code_protect), .EXT_RESP_OUT(ext_resp),
      .WRITE_BUSY_OUT(busy), .IRQ_HIGH_OUT(irq_high), .IRQ_LOW_OUT(irq_low));

   ext_prog_model ext_prog_model_inst (.clk_in(sys_clk), .req_out(ext_req), .resp_in(ext_resp));

   task automatic end_sim();
      if (n_errors == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   // generous ceiling: the whole sequence needs a few hundred cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         end_sim();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask : chk1

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk);
      sfr_req = '0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
      @(negedge sys_clk);
      sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge sys_clk);
      sfr_req = '0;
      chk8(sfr_rdata, exp, what);
   endtask : rd

   task automatic unlock_start();
      wr(12'hff2, 8'h00);
      wr(12'hfa6, 8'h04);
      wr(12'hfa7, 8'h55);
      wr(12'hfa7, 8'haa);
      wr(12'hfa6, 8'h06);
   endtask : unlock_start

   // busy cycles counted from the first cycle it shows high
   task automatic run_write(output int cnt);
      cnt = 0;
      repeat (4) if (busy !== 1'b1) @(negedge sys_clk);
      while (busy === 1'b1 && cnt < 200) begin
         cnt++;
         @(negedge sys_clk);
      end
   endtask : run_write

   task automatic t_reset_and_powerup();
      rd(12'hfa6, 8'h00, "control reset");
      rd(12'hfa9, 8'h00, "address reset");
      rd(12'hfa8, 8'h00, "data reset");
      rd(12'hfa0, 8'h00, "enable reset");
      rd(12'hfa1, 8'h00, "flags reset");
      rd(12'hfa2, 8'h1f, "priority reset");
      rd(12'hfa7, 8'h00, "key reads zero");
      rd(12'h123, 8'h00, "unmapped read");
      rd(12'hff2, 8'h00, "core irq reset");
      unlock_start();
      run_write(n);
      chk8(8'(n), 8'h00, "write during power-up timer");
      repeat (PWRT) @(negedge sys_clk);
   endtask : t_reset_and_powerup

   task automatic t_write_and_irq();
      code_protect = 1'b1;
      wr(12'hfa0, 8'h10);
      wr(12'hfa9, 8'h03);
      wr(12'hfa8, 8'h5a);
      unlock_start();
      run_write(n);
      chk8(8'(n), 8'(PROG), "programming length");
      rd(12'hfa6, 8'h04, "strobe cleared, enable kept");
      rd(12'hfa1, 8'h10, "done flag set");
      chk1(irq_high, 1'b1, "high irq");
      wr(12'hfa8, 8'h00);
      wr(12'hfa6, 8'h01);
      rd(12'hfa8, 8'h5a, "read back under protect");
      rd(12'hfa8, 8'h5a, "data held");
      wr(12'hfa2, 8'h0f);
      @(negedge sys_clk);
      chk1(irq_low, 1'b1, "low irq");
      chk1(irq_high, 1'b0, "high irq off");
      rd(12'hfa1, 8'h10, "flag sticky");
      wr(12'hfa1, 8'h00);
      @(negedge sys_clk);
      chk1(irq_low, 1'b0, "irq after clear");
      wr(12'hfa0, 8'h00);
   endtask : t_write_and_irq

   task automatic t_lock();
      wr(12'hfa9, 8'h04);
      wr(12'hfa8, 8'hc3);
      unlock_start();
      wr(12'hfa9, 8'h77);
      wr(12'hfa8, 8'h11);
      wr(12'hfa6, 8'h00);
      run_write(n);
      chk1(n > 0, 1'b1, "second write ran");
      rd(12'hfa9, 8'h04, "address locked");
      rd(12'hfa8, 8'hc3, "data locked");
      rd(12'hfa6, 8'h04, "control locked");
   endtask : t_lock

   task automatic t_refused();
      wr(12'hfa6, 8'h00);
      wr(12'hfa7, 8'h55);
      wr(12'hfa7, 8'haa);
      wr(12'hfa6, 8'h06);
      run_write(n);
      chk8(8'(n), 8'h00, "enable and strobe together");
      wr(12'hfa6, 8'h04);
      wr(12'hfa7, 8'h55);
      wr(12'hfa9, 8'h04);
      wr(12'hfa7, 8'haa);
      wr(12'hfa6, 8'h06);
      run_write(n);
      chk8(8'(n), 8'h00, "broken key sequence");
      wr(12'hfa7, 8'h55);
      wr(12'hfa7, 8'haa);
      wr(12'hfa6, 8'h46);
      run_write(n);
      chk8(8'(n), 8'h00, "write with config select");
      wr(12'hfa8, 8'h99);
      wr(12'hfa6, 8'h04);
      rd(12'hfa8, 8'h99, "zero read strobe");
      wr(12'hfa6, 8'h81);
      rd(12'hfa8, 8'h99, "read with select set");
      wr(12'hfa6, 8'h04);
   endtask : t_refused

   task automatic t_ext();
      ext_prog_model_inst.xfer(1'b0, 8'h03, 8'h00, r);
      chk1(r.valid & r.denied, 1'b1, "ext read protected");
      ext_prog_model_inst.xfer(1'b1, 8'h03, 8'hee, r);
      chk1(r.denied, 1'b1, "ext write protected");
      code_protect = 1'b0;
      ext_prog_model_inst.xfer(1'b0, 8'h04, 8'h00, r);
      chk8(r.rdata, 8'hc3, "ext read open");
      ext_prog_model_inst.xfer(1'b1, 8'h08, 8'h3c, r);
      ext_prog_model_inst.xfer(1'b0, 8'h08, 8'h00, r);
      chk1(r.valid & !r.denied, 1'b1, "ext access open");
      chk8(r.rdata, 8'h3c, "ext write open");
      wr(12'hfa9, 8'h03);
      wr(12'hfa6, 8'h05);
      rd(12'hfa8, 8'h5a, "protected write refused");
      // refresh: rewrite the byte just read back into the same cell
      unlock_start();
      ext_prog_model_inst.xfer(1'b0, 8'h03, 8'h00, r);
      chk1(r.denied, 1'b1, "ext refused while busy");
      run_write(n);
      chk8(8'(n), 8'(PROG - 2), "refresh busy remainder");
      ext_prog_model_inst.xfer(1'b0, 8'h03, 8'h00, r);
      chk8(r.rdata, 8'h5a, "refresh kept value");
   endtask : t_ext

   task automatic t_mid_reset();
      @(negedge sys_clk);
      rst_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      rd(12'hfa9, 8'h00, "address after reset");
      rd(12'hfa8, 8'h00, "data after reset");
      rd(12'hfa6, 8'h00, "enable after reset");
      rd(12'hfa1, 8'h00, "flags after reset");
   endtask : t_mid_reset

   initial begin
      repeat (3) @(negedge sys_clk);
      rst_n = 1'b1;
      t_reset_and_powerup();
      t_write_and_irq();
      t_lock();
      t_refused();
      t_ext();
      t_mid_reset();
      end_sim();
   end
endmodule : tb_data_eeprom_access_ctrl
